// ==== rtl/clk_ctrl.sv ====
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"
module clk_ctrl #(
    parameter int WIN_TICKS  = `WIN_TICKS,
    parameter int OSC_START  = `OSC_START,
    parameter int HALT_TICKS = `HALT_TICKS,
    parameter int SW_GAP     = `SW_GAP
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Core side, same clock
    input  wire logic                 sleep_instr,
    input  wire logic                 conv_enabled,
    input  wire logic [7:0]           factory_trim,
    // Wake requests from pins and async blocks
    input  wire clk_ctrl_pkg::wake_s  wake_in,
    // Clock control outputs
    output clk_ctrl_pkg::dom_en_s     dom_en,
    output clk_ctrl_pkg::src_en_s     src_en,
    output logic                      sys_tick,
    output logic                      cpu_halt,
    output logic                      conv_start,
    output logic [7:0]                osc_trim
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    if (WIN_TICKS < 1 || WIN_TICKS > 15) begin : g_bad_win
        $error("clk_ctrl: WIN_TICKS out of range");
    end
    if (OSC_START < 1 || OSC_START > 15) begin : g_bad_osc
        $error("clk_ctrl: OSC_START out of range");
    end
    if (HALT_TICKS < 1 || HALT_TICKS > 15) begin : g_bad_halt
        $error("clk_ctrl: HALT_TICKS out of range");
    end
    if (SW_GAP < 1 || SW_GAP > 15) begin : g_bad_gap
        $error("clk_ctrl: SW_GAP out of range");
    end

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [3:0] WIN_N  = 4'(WIN_TICKS);  // Window length
    localparam logic [3:0] OSC_N  = 4'(OSC_START);  // Start-up count
    localparam logic [3:0] HALT_N = 4'(HALT_TICKS); // Halt count
    localparam logic [3:0] GAP_N  = 4'(SW_GAP);     // Switch gap

    clk_ctrl_pkg::wake_s      wk_m_r;      // Sync stage one
    clk_ctrl_pkg::wake_s      wk_r;        // Sync stage two
    clk_ctrl_pkg::slp_state_e st_r;        // Sleep state
    logic [3:0]               div_code_r;  // Divider select
    logic [7:0]               trim_r;      // Oscillator trim
    logic [1:0]               src_r;       // Requested source
    logic [1:0]               src_act_r;   // Running source
    logic [3:0]               gap_r;       // Switch dead time
    logic [2:0]               slp_code_r;  // Sleep kind code
    logic                     slp_arm_r;   // Sleep arm
    logic [2:0]               slp_cur_r;   // Mode being slept
    logic [1:0]               pgate_r;     // Peripheral gating
    logic [3:0]               win_r;       // Protection window
    logic [3:0]               cnt_r;       // Wake counters
    logic                     tick;        // Divided tick
    logic [3:0]               div_act;     // Divider in use
    logic                     div_run;     // Divider may count
    logic                     acc;         // APB access phase
    logic                     wr_done;     // Write completes
    logic [7:0]               idx;         // Register index
    logic [7:0]               wdat;        // Write byte
    logic                     hit;         // Mapped address
    logic                     wake;        // Wake request
    logic                     sleep_go;    // Enter sleep

    // Register index from byte address
    function automatic logic [7:0] reg_idx(input logic [11:0] a);
        reg_idx = a[9:2];
    endfunction : reg_idx

    // Wake sources allowed by each mode
    function automatic logic wake_ok(input logic [2:0] m,
                                     input clk_ctrl_pkg::wake_s w);
        case (m)
            `SLP_IDLE:  wake_ok = |w;
            `SLP_NOISE: wake_ok = w.pin_change | w.ext_level
                                | w.conv | w.watchdog | w.supply;
            `SLP_PDOWN,
            `SLP_STBY:  wake_ok = w.pin_change | w.ext_level
                                | w.watchdog;
            default:    wake_ok = 1'b1;
        endcase
    endfunction : wake_ok

    // Legal sleep codes
    function automatic logic slp_valid(input logic [2:0] m);
        slp_valid = (m == `SLP_IDLE) || (m == `SLP_NOISE) ||
                    (m == `SLP_PDOWN) || (m == `SLP_STBY);
    endfunction : slp_valid

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Wake pins come from other domains
    always_ff @(posedge clk) begin
        if (rst) begin
            wk_m_r <= '0;
            wk_r   <= '0;
        end else begin
            wk_m_r <= wake_in;
            wk_r   <= wk_m_r;
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    assign acc     = psel && penable;
    assign wr_done = acc && pready && pwrite;
    assign idx     = reg_idx(paddr);
    assign wdat    = pwdata[7:0];
    assign hit     = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                     (idx == `IDX_DIV || idx == `IDX_TRIM ||
                      idx == `IDX_MAIN || idx == `IDX_GATE ||
                      idx == `IDX_SLEEP || idx == `IDX_PERIPH ||
                      idx == `IDX_STAT);

    // One wait state; answer registered
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !hit;
        end
    end

    // Read data, reserved bits zero
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (acc && !pready) begin
            prdata <= '0;
            case (idx)
                `IDX_DIV:    prdata[3:0] <= div_code_r;
                `IDX_TRIM:   prdata[7:0] <= trim_r;
                `IDX_MAIN:   prdata[1:0] <= src_r;
                `IDX_GATE:   prdata[0]   <= (win_r != 4'h0);
                `IDX_SLEEP:  prdata[3:0] <= {slp_code_r, slp_arm_r};
                `IDX_PERIPH: prdata[1:0] <= pgate_r;
                `IDX_STAT:   prdata[11:0] <= {div_act, 2'b00, src_act_r,
                                              2'b00, st_r};
                default:     prdata <= '0;
            endcase
        end
    end

    // ****************************************
    // Change protection window
    // ****************************************
    // Opens on signature, runs out in instruction cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            win_r <= 4'h0;
        end else if (wr_done && idx == `IDX_GATE && wdat == `GATE_SIG) begin
            win_r <= WIN_N;
        end else if (wr_done && (idx == `IDX_MAIN || idx == `IDX_DIV)) begin
            win_r <= 4'h0; // One protected write per signature
        end else if (tick && win_r != 4'h0) begin
            win_r <= win_r - 4'h1;
        end
    end

    // ****************************************
    // Settings registers
    // ****************************************
    // Divider select, protected
    always_ff @(posedge clk) begin
        if (rst) begin
            div_code_r <= `DIV_RST;
        end else if (wr_done && idx == `IDX_DIV && win_r != 4'h0 &&
                     wdat[3:0] <= `DIV_MAX) begin
            div_code_r <= wdat[3:0];
        end // Else kept
    end

    // Main source select, protected; reserved code ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            src_r <= `SRC_RC;
        end else if (wr_done && idx == `IDX_MAIN && win_r != 4'h0 &&
                     wdat[1:0] != `SRC_RSV) begin
            src_r <= wdat[1:0];
        end // Else kept
    end

    // Trim: factory value at reset, software may retune
    always_ff @(posedge clk) begin
        if (rst) begin
            trim_r <= factory_trim;
        end else if (wr_done && idx == `IDX_TRIM) begin
            trim_r <= wdat;
        end
    end

    // Sleep control and peripheral gating
    always_ff @(posedge clk) begin
        if (rst) begin
            slp_code_r <= `SLP_IDLE;
            slp_arm_r  <= 1'b0;
            pgate_r    <= 2'b00;
        end else if (wr_done && idx == `IDX_SLEEP) begin
            slp_code_r <= wdat[3:1];
            slp_arm_r  <= wdat[0];
        end else if (wr_done && idx == `IDX_PERIPH) begin
            pgate_r    <= wdat[1:0];
        end
    end

    // ****************************************
    // Glitch-free source switch
    // ****************************************
    // RC and external gates closed for a gap before the new one opens; watchdog gate stays open
    always_ff @(posedge clk) begin
        if (rst) begin
            src_act_r <= `SRC_RC;
            gap_r     <= 4'h0;
        end else if (src_r != src_act_r && gap_r == 4'h0) begin
            gap_r     <= GAP_N;
        end else if (gap_r == 4'h1) begin
            src_act_r <= src_r;
            gap_r     <= 4'h0;
        end else if (gap_r != 4'h0) begin
            gap_r     <= gap_r - 4'h1;
        end
    end

    // ****************************************
    // System clock divider
    // ****************************************
    // Counts only while the main clock would run
    assign div_run = (gap_r == 4'h0) &&
                     !(st_r == clk_ctrl_pkg::ST_SLEEP &&
                       (slp_cur_r == `SLP_PDOWN || slp_cur_r == `SLP_STBY));

    sys_div #(
        .CW     (8)
    ) u_div (
        .clk    (clk),
        .rst    (rst),
        .run    (div_run),
        .code   (div_code_r),
        .tick_r (tick),
        .act_r  (div_act)
    );

    // ****************************************
    // Sleep controller
    // ****************************************
    assign sleep_go = sleep_instr && slp_arm_r &&
                      slp_valid(slp_code_r);
    assign wake     = wake_ok(slp_cur_r, wk_r);

    // Reset in any state returns to run
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r      <= clk_ctrl_pkg::ST_RUN;
            slp_cur_r <= `SLP_IDLE;
            cnt_r     <= 4'h0;
        end else begin
            case (st_r)
                clk_ctrl_pkg::ST_RUN: begin
                    if (sleep_go) begin
                        st_r      <= clk_ctrl_pkg::ST_SLEEP;
                        slp_cur_r <= slp_code_r;
                    end
                end
                clk_ctrl_pkg::ST_SLEEP: begin
                    if (wake && slp_cur_r == `SLP_PDOWN) begin
                        st_r  <= clk_ctrl_pkg::ST_OSC;
                        cnt_r <= OSC_N;
                    end else if (wake) begin
                        st_r  <= clk_ctrl_pkg::ST_HALT;
                        cnt_r <= HALT_N;
                    end
                end
                clk_ctrl_pkg::ST_OSC: begin
                    // Start-up counted in main clock cycles
                    if (cnt_r == 4'h1) begin
                        st_r  <= clk_ctrl_pkg::ST_HALT;
                        cnt_r <= HALT_N;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                clk_ctrl_pkg::ST_HALT: begin
                    // Extra halt counted in instruction cycles
                    if (tick && cnt_r == 4'h1) begin
                        st_r  <= clk_ctrl_pkg::ST_RUN;
                        cnt_r <= 4'h0;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: begin
                    st_r <= clk_ctrl_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Clock domain gating outputs
    // ****************************************
    // Gated peripherals hold state; clocks stop, nothing reset
    always_ff @(posedge clk) begin
        if (rst) begin
            dom_en <= '{cpu: 1'b1, nvm: 1'b1, io: 1'b1,
                        conv: 1'b1, timer: 1'b1};
        end else if (st_r == clk_ctrl_pkg::ST_SLEEP) begin
            dom_en.cpu   <= 1'b0;
            dom_en.nvm   <= 1'b0;
            dom_en.io    <= (slp_cur_r == `SLP_IDLE);
            dom_en.conv  <= (slp_cur_r == `SLP_IDLE ||
                             slp_cur_r == `SLP_NOISE) &&
                            !pgate_r[`PG_CONV];
            dom_en.timer <= (slp_cur_r == `SLP_IDLE) &&
                            !pgate_r[`PG_TIMER];
        end else begin
            dom_en.cpu   <= (st_r == clk_ctrl_pkg::ST_RUN);
            dom_en.nvm   <= (st_r == clk_ctrl_pkg::ST_RUN);
            dom_en.io    <= 1'b1;
            dom_en.conv  <= !pgate_r[`PG_CONV];
            dom_en.timer <= !pgate_r[`PG_TIMER];
        end
    end

    // Source oscillators; watchdog oscillator always runs
    always_ff @(posedge clk) begin
        if (rst) begin
            src_en <= '{rc: 1'b1, wd: 1'b1, ext: 1'b0};
        end else begin
            src_en.rc  <= (src_act_r == `SRC_RC) && (gap_r == 4'h0) &&
                          !(st_r == clk_ctrl_pkg::ST_SLEEP &&
                            slp_cur_r == `SLP_PDOWN);
            src_en.wd  <= 1'b1;
            src_en.ext <= (src_act_r == `SRC_EXT) && (gap_r == 4'h0);
        end
    end

    // ****************************************
    // Tick, halt, trim and conversion start
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_tick   <= 1'b0;
            cpu_halt   <= 1'b0;
            conv_start <= 1'b0;
            osc_trim   <= 8'h00;
        end else begin
            sys_tick   <= tick;
            cpu_halt   <= (st_r != clk_ctrl_pkg::ST_RUN) || sleep_go;
            conv_start <= sleep_go && conv_enabled &&
                          !pgate_r[`PG_CONV] &&
                          (slp_code_r == `SLP_IDLE ||
                           slp_code_r == `SLP_NOISE);
            osc_trim   <= trim_r;
        end
    end
endmodule : clk_ctrl

// ==== common/clk_ctrl_params.svh ====
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH
// ****************************************
// Register indices (byte address = 4*index)
// ****************************************
`define IDX_DIV    8'h36 // Divider select
`define IDX_TRIM   8'h39 // Oscillator trim
`define IDX_MAIN   8'h3A // Main clock settings
`define IDX_GATE   8'h3B // Change protection gate
`define IDX_SLEEP  8'h3C // Sleep control
`define IDX_PERIPH 8'h3D // Peripheral gating
`define IDX_STAT   8'h3E // Block status
// ****************************************
// Reset values, codes, fields
// ****************************************
`define DIV_RST    4'h3  // Divide by 8
`define DIV_MAX    4'h8  // Divide by 256
`define SRC_RC     2'h0  // Internal 8 MHz
`define SRC_WD     2'h1  // 128 kHz oscillator
`define SRC_EXT    2'h2  // External input
`define SRC_RSV    2'h3  // Reserved
`define SLP_IDLE   3'h0
`define SLP_NOISE  3'h1
`define SLP_PDOWN  3'h2
`define SLP_STBY   3'h4
`define GATE_SIG   8'h5A // Arbitrary signature
`define PG_CONV    1     // Converter gate bit
`define PG_TIMER   0     // Timer gate bit
// ****************************************
// Timing counts
// ****************************************
`define WIN_TICKS  4     // Instruction cycles
`define OSC_START  6     // Main clock cycles
`define HALT_TICKS 4     // Instruction cycles
`define SW_GAP     2     // Dead cycles on switch
`endif

// ==== common/clk_ctrl_pkg.sv ====
package clk_ctrl_pkg;
    // Sleep controller states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OSC   = 2'b10,
        ST_HALT  = 2'b11
    } slp_state_e;
    // Clock domain enables
    typedef struct packed {
        logic cpu;
        logic nvm;
        logic io;
        logic conv;
        logic timer;
    } dom_en_s;
    // Source oscillator enables
    typedef struct packed {
        logic rc;
        logic wd;
        logic ext;
    } src_en_s;
    // Wake request inputs
    typedef struct packed {
        logic pin_change;
        logic ext_level;
        logic ext_edge;
        logic watchdog;
        logic supply;
        logic conv;
        logic other_io;
    } wake_s;
endpackage : clk_ctrl_pkg

// ==== rtl/sys_div.sv ====
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"
module sys_div #(
    parameter int CW = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic [3:0]   code,
    output logic              tick_r,
    output logic [3:0]        act_r
);
    // ****************************************
    // Power of two divider
    // ****************************************
    logic [CW-1:0] cnt_r; // Main clock count

    if (CW < 8) begin : g_bad
        $error("sys_div: CW too small for divide by 256");
    end

    // Terminal count for a code
    function automatic logic [CW-1:0] lim(input logic [3:0] c);
        lim = CW'((32'd1 << c) - 32'd1);
    endfunction : lim

    // Counter; new code only at period end so no short pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            act_r <= `DIV_RST;
        end else if (run) begin
            if (cnt_r >= lim(act_r)) begin
                cnt_r <= '0;
                act_r <= code;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // One tick per divided period
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= run && (cnt_r >= lim(act_r));
        end
    end
endmodule : sys_div

// ==== sim/clk_ctrl_asserts.sv ====
`timescale 1ns/1ps
// ************
// Port checker
// ************
module clk_ctrl_asserts (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                sleep_instr,
    input wire logic                conv_enabled,
    input wire logic [7:0]          factory_trim,
    input wire clk_ctrl_pkg::dom_en_s dom_en,
    input wire logic                cpu_halt,
    input wire logic                conv_start,
    input wire logic [7:0]          osc_trim
);
    // One domain, so one clock and one disable
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RSV_ZERO: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_CPU_NVM: assert property (dom_en.cpu == dom_en.nvm)
        else $error("core and memory clocks differ");
    AST_IO_CPU: assert property (!dom_en.io |-> !dom_en.cpu)
        else $error("io clock off with core running");
    AST_HALT_CAUSE: assert property ($rose(cpu_halt) |-> $past(sleep_instr))
        else $error("halt without sleep instruction");
    AST_CONV_START: assert property (conv_start |-> $past(conv_enabled) && $past(sleep_instr) ##1 !conv_start)
        else $error("stray conversion start");
    // Past depth three lets the trim path settle after release
    AST_TRIM_RST: assert property (!$past(rst) && !$past(rst, 2) && $past(rst, 3) |-> osc_trim == factory_trim)
        else $error("factory trim not loaded");
    AST_CPU_OFF: assert property (!dom_en.cpu |-> cpu_halt)
        else $error("core clock off while not halted");
    AST_WAKE_RUN: assert property ($fell(cpu_halt) |-> dom_en.cpu)
        else $error("core released without clock");
endmodule : clk_ctrl_asserts
bind clk_ctrl clk_ctrl_asserts u_chk (.clk(clk), .rst(rst), .pready(pready), .prdata(prdata),
    .sleep_instr(sleep_instr), .conv_enabled(conv_enabled), .factory_trim(factory_trim),
    .dom_en(dom_en), .cpu_halt(cpu_halt), .conv_start(conv_start), .osc_trim(osc_trim));

// ==== sim/test_clk_ctrl.sv ====
`timescale 1ns/1ps
module test_clk_ctrl;
    // ********
    // Stimulus
    // ********
    typedef struct packed {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] e; logic er;} row_s;
    typedef struct packed {logic [3:0] s; logic [6:0] bad; logic [6:0] good; logic io; logic cv; logic rc;} mode_s;
    logic                   clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep_instr = 0;
    logic                   conv_enabled = 1, pready, pslverr, sys_tick, cpu_halt, conv_start, er;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0]             factory_trim = 8'h6c, osc_trim;
    clk_ctrl_pkg::wake_s    wake_in = '0;
    clk_ctrl_pkg::dom_en_s  dom_en;
    clk_ctrl_pkg::src_en_s  src_en;
    int                     err_count = 0, n_tests = 0, n, i;
    row_s rows [13] = '{'{12'h0d8,1'b0,8'h00,8'h03,1'b0}, '{12'h0e4,1'b0,8'h00,8'h6c,1'b0},
        '{12'h0e8,1'b0,8'h00,8'h00,1'b0}, '{12'h0e4,1'b1,8'ha5,8'h00,1'b0},
        '{12'h0e4,1'b0,8'h00,8'ha5,1'b0}, '{12'h0e8,1'b1,8'h01,8'h00,1'b0},
        '{12'h0e8,1'b0,8'h00,8'h00,1'b0}, '{12'h0d8,1'b1,8'h05,8'h00,1'b0},
        '{12'h0d8,1'b0,8'h00,8'h03,1'b0}, '{12'h0f0,1'b1,8'hff,8'h00,1'b0},
        '{12'h0f0,1'b0,8'h00,8'h0f,1'b0}, '{12'h100,1'b1,8'h11,8'h00,1'b1},
        '{12'h100,1'b0,8'h00,8'h00,1'b1}};
    // Idle, noise, power-down, standby with wake sources that must not work (none for idle) and one that must
    mode_s modes [4] = '{'{4'h1,7'h00,7'h01,1,1,1}, '{4'h3,7'h11,7'h20,0,1,1},
        '{4'h5,7'h07,7'h08,0,0,0}, '{4'h9,7'h10,7'h40,0,0,1}};
    clk_ctrl dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sleep_instr(sleep_instr),
        .conv_enabled(conv_enabled), .factory_trim(factory_trim), .wake_in(wake_in), .dom_en(dom_en),
        .src_en(src_en), .sys_tick(sys_tick), .cpu_halt(cpu_halt), .conv_start(conv_start), .osc_trim(osc_trim));
    always #10 clk = ~clk;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; held until pready is seen at a rising edge
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int k;
        @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h00_0000, d};
        @(posedge clk) penable <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (k == 50) err_count++;
    endtask : apb
    task rchk(input logic [11:0] a, input logic [7:0] e);
        apb(a, 0, 8'h00);
        check(rd, {24'h00_0000, e});
    endtask : rchk
    // Window opened then protected write, nothing in between
    task prot(input logic [11:0] a, input logic [7:0] d);
        apb(12'h0ec, 1, 8'h5a);
        apb(a, 1, d);
    endtask : prot
    task period(output int p);
        p = 0;
        do @(posedge clk); while (sys_tick !== 1'b1);
        do begin @(posedge clk); p++; end while (sys_tick !== 1'b1 && p < 600);
    endtask : period
    task do_reset;
        @(posedge clk) rst <= 1; // Raised on an edge, never between them
        repeat (12) @(posedge clk);
        rst <= 0;
    endtask : do_reset
    task stop_test;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    // ***********
    // Main thread
    // ***********
    initial begin
        do_reset();
        foreach (rows[r]) begin
            apb(rows[r].a, rows[r].w, rows[r].d);
            if (!rows[r].w) check(rd, {24'h00_0000, rows[r].e});
            check(er, rows[r].er);
        end
        check(osc_trim, 8'ha5);
        prot(12'h0e8, 8'h02);
        rchk(12'h0e8, 8'h02);
        repeat (8) @(posedge clk);
        check(src_en.ext, 1);
        prot(12'h0e8, 8'h03);
        rchk(12'h0e8, 8'h02);
        prot(12'h0e8, 8'h00);
        apb(12'h0ec, 1, 8'h5a);
        repeat (40) @(posedge clk);
        apb(12'h0d8, 1, 8'h00);
        rchk(12'h0d8, 8'h03);
        for (i = 0; i <= 8; i++) begin
            prot(12'h0d8, i[7:0]);
            rchk(12'h0d8, i[7:0]);
            period(n);
            period(n);
            check(n, 1 << i);
        end
        prot(12'h0d8, 8'h09);
        rchk(12'h0d8, 8'h08);
        prot(12'h0d8, 8'h03);
        apb(12'h0f4, 1, 8'hff);
        rchk(12'h0f4, 8'h03);
        check({dom_en.conv, dom_en.timer}, 2'b00);
        apb(12'h0f4, 1, 8'h00);
        repeat (2) @(posedge clk); // Gate write lands, then the enable register follows
        check({dom_en.conv, dom_en.timer}, 2'b11);
        foreach (modes[m]) begin
            apb(12'h0f0, 1, {4'h0, modes[m].s});
            @(posedge clk) sleep_instr <= 1;
            @(posedge clk) sleep_instr <= 0;
            #1 check({cpu_halt, conv_start}, {1'b1, modes[m].cv});
            repeat (3) @(posedge clk);
            #1 check({dom_en.cpu, dom_en.io, dom_en.conv, src_en.rc}, {1'b0, modes[m].io, modes[m].cv, modes[m].rc});
            wake_in <= modes[m].bad;
            repeat (20) @(posedge clk);
            check(cpu_halt, 1);
            wake_in <= modes[m].good;
            n = 0;
            while (cpu_halt !== 1'b0 && n < 400) begin @(posedge clk); n++; end
            wake_in <= '0;
            check(dom_en.cpu, 1);
        end
        apb(12'h0f0, 1, 8'h04);
        @(posedge clk) sleep_instr <= 1;
        @(posedge clk) sleep_instr <= 0;
        #1 check(cpu_halt, 0);
        do_reset();
        rchk(12'h0d8, 8'h03);
        rchk(12'h0e4, 8'h6c);
        stop_test();
    end
    // Hang guard, far beyond the expected run
    initial begin
        #1_000_000;
        err_count++;
        stop_test();
    end
endmodule : test_clk_ctrl
